//--- common/timer_map.vh
// Register map, fields, reset values and timing of the 8-bit timer core
// Function
// - Count and compare registers are eight bits
// - Flags visible; each request gated by mask
// - Async select takes tick from crystal pin
// - Reset selects io clock, synchronous mode
// - Clock select zero stops the counter
// - Each tick clears, increments or decrements count
// - Count readable and writable without tick
// - Count write beats clear and count
// - Mode field split over control A, B
// - Overflow flag per mode, maskable request
// - Compares feed waveform outputs A and B
// - Compare match sets channel compare flag
// - Bottom indication when count is zero
// - Count 255 is the maximum
// - Top is maximum or compare A
// - Crystal source sampled on io clock; rising edges give ticks
// - Compare flag set on tick after match
// - Normal mode counts up, wraps, flags overflow
`ifndef TIMER_MAP_VH
`define TIMER_MAP_VH
`define OFS_COUNT       8'h00
`define OFS_CMP_A       8'h01
`define OFS_CMP_B       8'h02
`define OFS_CTRL_A      8'h03
`define OFS_CTRL_B      8'h04
`define OFS_IRQ_FLAG    8'h05
`define OFS_IRQ_MASK    8'h06
`define OFS_ASYNC_STAT  8'h07
`define OFS_POWER_RED   8'h08
`define BIT_ASYNC_SEL   5
`define BIT_POWER_OFF   6
`define BIT_WGM2        3
`define BIT_TOV         0
`define BIT_OCF_A       1
`define BIT_OCF_B       2
`define RST_BYTE        8'h00
`define CNT_BOTTOM      8'h00
`define CNT_MAX         8'hff
`define MODE_NORMAL     3'h0
`define MODE_PC_MAX     3'h1
`define MODE_CTC        3'h2
`define MODE_FAST_MAX   3'h3
`define MODE_PC_OCRA    3'h5
`define MODE_FAST_OCRA  3'h7
`define XTAL_HZ         32768
`define IO_CLK_HZ       100000000
`define XTAL_MIN_CYCLES ((`IO_CLK_HZ / `XTAL_HZ) / 2)
`endif

//--- src/timer_core.v
// 8-bit up/down timer core with compare channels and crystal clock option
`timescale 1ns/100ps
`include "timer_map.vh"
module timer_core #(
    parameter PRE_W = 10
) (
    input  wire       i_mclk,
    input  wire       i_reset_n,
    input  wire [7:0] i_addr,
    input  wire [7:0] i_wdata,
    input  wire       i_wr,
    input  wire       i_rd,
    output reg  [7:0] o_rdata,
    input  wire [2:0] i_irq_ack,
    output wire [2:0] o_irq_request,
    input  wire       i_crystal_osc_pin_in,
    output reg        o_crystal_osc_pin_out,
    output reg        o_compare_output_a,
    output wire       o_compare_output_a_en,
    output reg        o_compare_output_b,
    output wire       o_compare_output_b_en,
    output wire       o_bottom,
    output wire       o_max,
    output wire       o_top
);

    reg  [7:0]       count_value_q;
    reg  [7:0]       count_value_d;
    reg  [7:0]       compare_value_a_q;
    reg  [7:0]       compare_value_b_q;
    reg  [7:0]       cmp_buf_a_q;
    reg  [7:0]       cmp_buf_b_q;
    reg  [7:0]       control_reg_a_q;
    reg  [7:0]       control_reg_b_q;
    reg  [2:0]       flag_q;
    reg  [2:0]       flag_d;
    reg  [2:0]       mask_q;
    reg              async_clock_select_q;
    reg              timer_power_off_bit_q;
    reg              dir_down_q;
    reg              dir_down_d;
    reg              block_q;
    reg  [PRE_W-1:0] pre_q;
    reg              xtal_s1_q;
    reg              xtal_s2_q;
    reg              xtal_s3_q;
    reg              pre_tick;
    reg              tov_set;
    reg              out_a_d;
    reg              out_b_d;
    wire [2:0]       waveform_mode_field;
    wire [2:0]       clock_select_field;
    wire             src_tick;
    wire             timer_tick;
    wire             pwm_mode;
    wire             fast_mode;
    wire             pc_mode;
    wire [7:0]       top_value;
    wire             at_top;
    wire             match_a;
    wire             match_b;
    wire             cnt_wr;

    // Mode field is split across the two control registers
    assign waveform_mode_field = {control_reg_b_q[`BIT_WGM2],
                                  control_reg_a_q[1:0]};
    assign clock_select_field  = control_reg_b_q[2:0];
    assign pwm_mode  = (waveform_mode_field == `MODE_PC_MAX) ||
                       (waveform_mode_field == `MODE_FAST_MAX) ||
                       (waveform_mode_field == `MODE_PC_OCRA) ||
                       (waveform_mode_field == `MODE_FAST_OCRA);
    assign fast_mode = (waveform_mode_field == `MODE_FAST_MAX) ||
                       (waveform_mode_field == `MODE_FAST_OCRA);
    assign pc_mode   = (waveform_mode_field == `MODE_PC_MAX) ||
                       (waveform_mode_field == `MODE_PC_OCRA);
    assign top_value = ((waveform_mode_field == `MODE_CTC) ||
                        (waveform_mode_field == `MODE_PC_OCRA) ||
                        (waveform_mode_field == `MODE_FAST_OCRA)) ?
                       compare_value_a_q : `CNT_MAX;
    assign at_top    = (count_value_q == top_value);
    assign o_top     = at_top;
    assign o_max     = (count_value_q == `CNT_MAX);
    assign o_bottom  = (count_value_q == `CNT_BOTTOM);
    assign match_a   = (count_value_q == compare_value_a_q);
    assign match_b   = (count_value_q == compare_value_b_q);
    assign cnt_wr    = i_wr && (i_addr == `OFS_COUNT);

    // Crystal pin is asynchronous; the first stage feeds only the second
    always @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            xtal_s1_q <= 1'b0;
            xtal_s2_q <= 1'b0;
            xtal_s3_q <= 1'b0;
            o_crystal_osc_pin_out <= 1'b1;
        end else begin
            xtal_s1_q <= i_crystal_osc_pin_in;
            xtal_s2_q <= xtal_s1_q;
            xtal_s3_q <= xtal_s2_q;
            o_crystal_osc_pin_out <= ~xtal_s2_q;
        end
    end

    // Rising crystal edge is one source tick; io clock ticks every cycle
    assign src_tick = async_clock_select_q ?
                      (xtal_s2_q && !xtal_s3_q) : 1'b1;

    // Prescaler runs on source ticks and is kept free running
    always @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pre_q <= {PRE_W{1'b0}};
        end else if (src_tick) begin
            pre_q <= pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
        end
    end

    always @* begin
        pre_tick = 1'b0;
        case (clock_select_field)
            3'h0: pre_tick = 1'b0;
            3'h1: pre_tick = 1'b1;
            3'h2: pre_tick = (pre_q[2:0] == 3'h7);
            3'h3: pre_tick = (pre_q[4:0] == 5'h1f);
            3'h4: pre_tick = (pre_q[5:0] == 6'h3f);
            3'h5: pre_tick = (pre_q[6:0] == 7'h7f);
            3'h6: pre_tick = (pre_q[7:0] == 8'hff);
            default: pre_tick = (pre_q == {PRE_W{1'b1}});
        endcase
    end

    // A powered-down timer gets no ticks at all
    assign timer_tick = src_tick && pre_tick && !timer_power_off_bit_q;

    // Counter sequence per mode; a software write wins over everything
    always @* begin
        count_value_d = count_value_q;
        dir_down_d    = dir_down_q;
        tov_set       = 1'b0;
        if (cnt_wr) begin
            count_value_d = i_wdata;
        end else if (timer_tick) begin
            if (pc_mode) begin
                if (!dir_down_q) begin
                    if (at_top) begin
                        dir_down_d    = 1'b1;
                        count_value_d = count_value_q - 8'h01;
                    end else begin
                        count_value_d = count_value_q + 8'h01;
                    end
                end else begin
                    if (count_value_q == `CNT_BOTTOM) begin
                        dir_down_d    = 1'b0;
                        tov_set       = 1'b1;
                        count_value_d = count_value_q + 8'h01;
                    end else begin
                        count_value_d = count_value_q - 8'h01;
                    end
                end
            end else if (waveform_mode_field == `MODE_CTC) begin
                if (at_top) begin
                    count_value_d = `CNT_BOTTOM;
                end else begin
                    count_value_d = count_value_q + 8'h01;
                end
                tov_set = o_max;
            end else if (fast_mode) begin
                if (at_top) begin
                    count_value_d = `CNT_BOTTOM;
                    tov_set       = 1'b1;
                end else begin
                    count_value_d = count_value_q + 8'h01;
                end
            end else begin
                // Normal and reserved codes: plain up count with wrap
                count_value_d = count_value_q + 8'h01;
                tov_set       = o_max;
                dir_down_d    = 1'b0;
            end
        end
    end

    // Flags: hardware set wins over software clear and acknowledge
    always @* begin
        flag_d = flag_q;
        if (i_wr && (i_addr == `OFS_IRQ_FLAG)) begin
            flag_d = flag_d & ~i_wdata[2:0];
        end
        flag_d = flag_d & ~i_irq_ack;
        if (tov_set) begin
            flag_d[`BIT_TOV] = 1'b1;
        end
        if (timer_tick && match_a && !block_q) begin
            flag_d[`BIT_OCF_A] = 1'b1;
        end
        if (timer_tick && match_b && !block_q) begin
            flag_d[`BIT_OCF_B] = 1'b1;
        end
    end

    assign o_irq_request = flag_q & mask_q;

    // Waveform outputs from compare results and output mode bits
    always @* begin
        out_a_d = o_compare_output_a;
        out_b_d = o_compare_output_b;
        if (timer_tick && !block_q) begin
            if (!pwm_mode) begin
                if (match_a) begin
                    case (control_reg_a_q[7:6])
                        2'h1: out_a_d = ~o_compare_output_a;
                        2'h2: out_a_d = 1'b0;
                        2'h3: out_a_d = 1'b1;
                        default: out_a_d = o_compare_output_a;
                    endcase
                end
                if (match_b) begin
                    case (control_reg_a_q[5:4])
                        2'h1: out_b_d = ~o_compare_output_b;
                        2'h2: out_b_d = 1'b0;
                        2'h3: out_b_d = 1'b1;
                        default: out_b_d = o_compare_output_b;
                    endcase
                end
            end else if (fast_mode) begin
                if (match_a && control_reg_a_q[7]) begin
                    out_a_d = control_reg_a_q[6];
                end else if (at_top && control_reg_a_q[7]) begin
                    out_a_d = ~control_reg_a_q[6];
                end
                if (match_b && control_reg_a_q[5]) begin
                    out_b_d = control_reg_a_q[4];
                end else if (at_top && control_reg_a_q[5]) begin
                    out_b_d = ~control_reg_a_q[4];
                end
            end else begin
                // Phase correct: level depends on count direction at match
                if (match_a && control_reg_a_q[7]) begin
                    out_a_d = control_reg_a_q[6] ^ dir_down_q;
                end
                if (match_b && control_reg_a_q[5]) begin
                    out_b_d = control_reg_a_q[4] ^ dir_down_q;
                end
            end
        end
    end

    assign o_compare_output_a_en = (control_reg_a_q[7:6] != 2'h0);
    assign o_compare_output_b_en = (control_reg_a_q[5:4] != 2'h0);

    always @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count_value_q      <= `RST_BYTE;
            dir_down_q         <= 1'b0;
            flag_q             <= 3'h0;
            block_q            <= 1'b0;
            o_compare_output_a <= 1'b0;
            o_compare_output_b <= 1'b0;
        end else begin
            count_value_q      <= count_value_d;
            dir_down_q         <= dir_down_d;
            flag_q             <= flag_d;
            o_compare_output_a <= out_a_d;
            o_compare_output_b <= out_b_d;
            // A count write masks compare matches on the next tick only
            if (cnt_wr) begin
                block_q <= 1'b1;
            end else if (timer_tick) begin
                block_q <= 1'b0;
            end
        end
    end

    // Register writes; compares are double buffered only in PWM modes
    always @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            compare_value_a_q     <= `RST_BYTE;
            compare_value_b_q     <= `RST_BYTE;
            cmp_buf_a_q           <= `RST_BYTE;
            cmp_buf_b_q           <= `RST_BYTE;
            control_reg_a_q       <= `RST_BYTE;
            control_reg_b_q       <= `RST_BYTE;
            mask_q                <= 3'h0;
            async_clock_select_q  <= 1'b0;
            timer_power_off_bit_q <= 1'b0;
        end else begin
            if (i_wr && (i_addr == `OFS_CMP_A)) begin
                cmp_buf_a_q <= i_wdata;
            end
            if (i_wr && (i_addr == `OFS_CMP_B)) begin
                cmp_buf_b_q <= i_wdata;
            end
            // Buffered update at top keeps PWM pulses symmetrical
            if (!pwm_mode) begin
                if (i_wr && (i_addr == `OFS_CMP_A)) begin
                    compare_value_a_q <= i_wdata;
                end
                if (i_wr && (i_addr == `OFS_CMP_B)) begin
                    compare_value_b_q <= i_wdata;
                end
            end else if (timer_tick && at_top) begin
                compare_value_a_q <= cmp_buf_a_q;
                compare_value_b_q <= cmp_buf_b_q;
            end
            if (i_wr && (i_addr == `OFS_CTRL_A)) begin
                control_reg_a_q <= {i_wdata[7:4], 2'h0, i_wdata[1:0]};
            end
            if (i_wr && (i_addr == `OFS_CTRL_B)) begin
                control_reg_b_q <= {4'h0, i_wdata[3:0]};
            end
            if (i_wr && (i_addr == `OFS_IRQ_MASK)) begin
                mask_q <= i_wdata[2:0];
            end
            if (i_wr && (i_addr == `OFS_ASYNC_STAT)) begin
                async_clock_select_q <= i_wdata[`BIT_ASYNC_SEL];
            end
            if (i_wr && (i_addr == `OFS_POWER_RED)) begin
                timer_power_off_bit_q <= i_wdata[`BIT_POWER_OFF];
            end
        end
    end

    // Read data appear one cycle after the strobe; unmapped reads zero
    always @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            if (i_addr == `OFS_COUNT) begin
                o_rdata <= count_value_q;
            end else if (i_addr == `OFS_CMP_A) begin
                o_rdata <= cmp_buf_a_q;
            end else if (i_addr == `OFS_CMP_B) begin
                o_rdata <= cmp_buf_b_q;
            end else if (i_addr == `OFS_CTRL_A) begin
                o_rdata <= control_reg_a_q;
            end else if (i_addr == `OFS_CTRL_B) begin
                o_rdata <= control_reg_b_q;
            end else if (i_addr == `OFS_IRQ_FLAG) begin
                o_rdata <= {5'h00, flag_q};
            end else if (i_addr == `OFS_IRQ_MASK) begin
                o_rdata <= {5'h00, mask_q};
            end else if (i_addr == `OFS_ASYNC_STAT) begin
                o_rdata <= {2'h0, async_clock_select_q, 5'h00};
            end else if (i_addr == `OFS_POWER_RED) begin
                o_rdata <= {1'b0, timer_power_off_bit_q, 6'h00};
            end else begin
                o_rdata <= 8'h00;
            end
        end else begin
            o_rdata <= 8'h00;
        end
    end

endmodule // timer_core

//--- verif/crystal_model.sv
// Watch-crystal source that produces pulses only on request
`timescale 1ns/100ps
module crystal_model #(
    parameter HALF_NS = 73
) (
    output logic o_pin
);
    // Rests low between bursts, so every counted tick is one the bench asked for
    initial o_pin = 1'b0;
    // Period is unrelated to the 10 ns core clock
    task automatic burst(input int n);
        repeat (n) begin
            #(HALF_NS) o_pin = 1'b1;
            #(HALF_NS) o_pin = 1'b0;
        end
    endtask
endmodule // crystal_model

//--- verif/timer_core_asserts.sv
// Port-level assertions for the timer core
`timescale 1ns/100ps
`include "timer_map.vh"
module timer_core_asserts (
    input wire       i_mclk,
    input wire       i_reset_n,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire       i_wr,
    input wire       i_rd,
    input wire [7:0] o_rdata,
    input wire [2:0] i_irq_ack,
    input wire [2:0] o_irq_request,
    input wire       i_crystal_osc_pin_in,
    input wire       o_crystal_osc_pin_out,
    input wire       o_compare_output_a,
    input wire       o_compare_output_a_en,
    input wire       o_compare_output_b,
    input wire       o_compare_output_b_en,
    input wire       o_bottom,
    input wire       o_max,
    input wire       o_top
);
    // Shadow of control writes, so mode checks need no internal probes
    logic [2:0] mask_q;
    logic [1:0] ctla_q;
    logic [3:0] ctlb_q;
    wire        wr_cnt = i_wr && i_addr == `OFS_COUNT;
    wire        rd_cnt = i_rd && i_addr == `OFS_COUNT;
    wire        normal = {ctlb_q[3], ctla_q} == `MODE_NORMAL;
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mask_q <= 3'h0;
            ctla_q <= 2'h0;
            ctlb_q <= 4'h0;
        end else if (i_wr) begin
            if (i_addr == `OFS_IRQ_MASK) mask_q <= i_wdata[2:0];
            if (i_addr == `OFS_CTRL_A) ctla_q <= i_wdata[1:0];
            if (i_addr == `OFS_CTRL_B) ctlb_q <= i_wdata[3:0];
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    mask_gates_req_a: assert property ((o_irq_request & ~mask_q) == 3'h0)
        else $error("request raised for a masked flag");
    write_wins_a: assert property (wr_cnt |=> o_bottom == ($past(i_wdata) == 8'h00))
        else $error("count write lost against a tick");
    max_marks_ff_a: assert property (wr_cnt |=> o_max == ($past(i_wdata) == `CNT_MAX))
        else $error("max indication wrong after count write");
    bottom_read_a: assert property (rd_cnt |=> (o_rdata == 8'h00) == $past(o_bottom))
        else $error("bottom indication disagrees with count read");
    count_readback_a: assert property (wr_cnt ##1 rd_cnt |=> o_rdata == $past(i_wdata, 2))
        else $error("count read does not return written value");
    stopped_hold_a: assert property (ctlb_q[2:0] == 3'h0 && $past(ctlb_q[2:0]) == 3'h0 && !i_wr
        |=> $stable(o_bottom) && $stable(o_max))
        else $error("count moved with no clock selected");
    normal_top_a: assert property (normal |-> o_top == o_max)
        else $error("top differs from max in normal mode");
    wrap_overflow_a: assert property ($rose(o_bottom) && $past(o_max) && !$past(i_wr) && normal
        && mask_q[0] |-> o_irq_request[0])
        else $error("no overflow request on wrap");
    cover property ($rose(o_irq_request[0]));
    cover property ($rose(o_bottom) && $past(o_max));
    cover property (wr_cnt ##1 rd_cnt);
endmodule // timer_core_asserts
bind timer_core timer_core_asserts timer_core_asserts_i (
    .i_mclk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_irq_ack, .o_irq_request,
    .i_crystal_osc_pin_in, .o_crystal_osc_pin_out, .o_compare_output_a, .o_compare_output_a_en,
    .o_compare_output_b, .o_compare_output_b_en, .o_bottom, .o_max, .o_top);

//--- verif/testbench.sv
// Self-checking bench for the timer core
`timescale 1ns/100ps
`include "timer_map.vh"
module testbench;
    logic       i_mclk    = 1'b0;
    logic       i_reset_n = 1'b0;
    logic [7:0] i_addr    = 8'h00;
    logic [7:0] i_wdata   = 8'h00;
    logic       i_wr      = 1'b0;
    logic       i_rd      = 1'b0;
    logic [2:0] i_irq_ack = 3'h0;
    wire  [7:0] o_rdata;
    wire  [2:0] o_irq_request;
    wire        i_crystal_osc_pin_in;
    wire        o_crystal_osc_pin_out, o_compare_output_a, o_compare_output_a_en;
    wire        o_compare_output_b, o_compare_output_b_en, o_bottom, o_max, o_top;
    int         bad_count = 0;
    int         total_checks = 0;
    always #5 i_mclk = ~i_mclk;
    timer_core timer_core_i (
        .i_mclk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_irq_ack, .o_irq_request,
        .i_crystal_osc_pin_in, .o_crystal_osc_pin_out, .o_compare_output_a, .o_compare_output_a_en,
        .o_compare_output_b, .o_compare_output_b_en, .o_bottom, .o_max, .o_top);
    crystal_model crystal_model_i (.o_pin(i_crystal_osc_pin_in));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Expected count after one tick in clear-on-compare mode
    function automatic logic [7:0] ctc_next(input logic [7:0] c, input logic [7:0] top);
        return (c == top) ? `CNT_BOTTOM : c + 8'h01;
    endfunction
    // Expected request lines for a set of flags under a mask
    function automatic logic [7:0] exp_req(input logic [2:0] f, input logic [2:0] m);
        return {5'h0, f & m};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    // All bus tasks start and end 1 ns after an edge, clear of the sampling point
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask
    task automatic chkrd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp);
    endtask
    task automatic wait_req(input int idx);
        int k;
        for (k = 0; k < 600 && o_irq_request[idx] !== 1'b1; k++) cyc(1);
        if (k == 600) begin
            bad_count++;
            report_and_stop();
        end
    endtask
    initial begin
        #500000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        int i;
        logic [7:0] a;
        logic [7:0] d;
        d = 8'($urandom(32'hce8bc2ce));
        repeat (4) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        cyc(1);
        // Every mapped register plus one unmapped place reads zero
        for (i = 0; i < 10; i++) begin
            a = (i == 9) ? 8'h20 : i[7:0];
            chkrd(a, `RST_BYTE);
        end
        for (i = 0; i < 12; i++) begin
            a = 8'(i % 3);
            d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
            wr(a, d);
            cyc(2);
            chkrd(a, d);
        end
        wr(`OFS_COUNT, 8'h33);
        cyc(20);
        chkrd(`OFS_COUNT, 8'h33);
        wr(`OFS_CMP_A, 8'h30);
        wr(`OFS_COUNT, 8'h30);
        wr(`OFS_CTRL_A, {5'h0, `MODE_CTC});
        chk({7'h0, o_top}, 8'h01);
        chk({7'h0, o_max}, 8'h00);
        wr(`OFS_CTRL_A, 8'h01);
        wr(`OFS_CTRL_B, 8'h08);
        chk({7'h0, o_top}, 8'h01);
        wr(`OFS_CTRL_B, 8'h00);
        chk({7'h0, o_top}, 8'h00);
        wr(`OFS_CTRL_A, 8'h00);
        wr(`OFS_COUNT, `CNT_MAX);
        chk({6'h0, o_top, o_max}, 8'h03);
        wr(`OFS_COUNT, `CNT_BOTTOM);
        chk({7'h0, o_bottom}, 8'h01);
        // Free run in normal mode through a wrap and both compare points
        wr(`OFS_CMP_A, 8'h10);
        wr(`OFS_CMP_B, 8'h20);
        wr(`OFS_IRQ_MASK, 8'h01);
        wr(`OFS_IRQ_FLAG, 8'h07);
        wr(`OFS_COUNT, 8'hfd);
        wr(`OFS_CTRL_B, 8'h01);
        wait_req(0);
        chk({5'h0, o_irq_request}, 8'h01);
        cyc(40);
        chk({5'h0, o_irq_request}, exp_req(3'h7, 3'h1));
        chkrd(`OFS_IRQ_FLAG, 8'h07);
        wr(`OFS_IRQ_MASK, 8'h06);
        chk({5'h0, o_irq_request}, exp_req(3'h7, 3'h6));
        i_irq_ack <= 3'b010;
        cyc(1);
        i_irq_ack <= 3'b000;
        chkrd(`OFS_IRQ_FLAG, 8'h05);
        wr(`OFS_IRQ_FLAG, 8'h05);
        chkrd(`OFS_IRQ_FLAG, 8'h00);
        wr(`OFS_COUNT, 8'h55);
        chkrd(`OFS_COUNT, 8'h55);
        rd(`OFS_COUNT, d);
        chkrd(`OFS_COUNT, d + 8'h01);
        wr(`OFS_CTRL_B, 8'h00);
        rd(`OFS_COUNT, d);
        cyc(30);
        chkrd(`OFS_COUNT, d);
        wr(`OFS_POWER_RED, 8'h40);
        wr(`OFS_CTRL_B, 8'h01);
        rd(`OFS_COUNT, d);
        cyc(30);
        chkrd(`OFS_COUNT, d);
        wr(`OFS_POWER_RED, 8'h00);
        rd(`OFS_COUNT, d);
        chkrd(`OFS_COUNT, d + 8'h01);
        // Toggle on match in normal mode; both outputs start low after reset
        wr(`OFS_CTRL_B, 8'h00);
        wr(`OFS_CTRL_A, 8'h50);
        chk({6'h0, o_compare_output_a_en, o_compare_output_b_en}, 8'h03);
        wr(`OFS_COUNT, 8'h0e);
        wr(`OFS_CTRL_B, 8'h01);
        cyc(40);
        chk({6'h0, o_compare_output_a, o_compare_output_b}, 8'h03);
        // Clear on compare with a random top, starting on the top itself
        a = 8'h04 + 8'($urandom % 8);
        wr(`OFS_CMP_A, a);
        wr(`OFS_CTRL_A, 8'h02);
        wr(`OFS_COUNT, a);
        for (i = 0; i < 16; i++) begin
            rd(`OFS_COUNT, d);
            chkrd(`OFS_COUNT, ctc_next(d, a));
            cyc(1 + ($urandom % 3));
        end
        // Crystal source: io clock must no longer advance the count
        wr(`OFS_CTRL_B, 8'h00);
        wr(`OFS_CTRL_A, 8'h00);
        wr(`OFS_ASYNC_STAT, 8'h20);
        wr(`OFS_COUNT, 8'h00);
        wr(`OFS_CTRL_B, 8'h01);
        cyc(20);
        chkrd(`OFS_COUNT, 8'h00);
        chk({7'h0, o_crystal_osc_pin_out}, 8'h01);
        crystal_model_i.burst(5);
        cyc(10);
        chkrd(`OFS_COUNT, 8'h05);
        report_and_stop();
    end
endmodule // testbench
